// file: verilog/iofdj_pkg.sv
package iofdj_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_MENU = 8'h00;
  localparam logic [7:0] OFF_SPECIAL = 8'h04;
  localparam logic [7:0] OFF_FORCED = 8'h08;
  localparam logic [7:0] OFF_OUTCFG = 8'h0C;
  localparam logic [7:0] OFF_JOGSPD = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_DISPLAY = 8'h18;
  localparam logic [7:0] OFF_FAULT0 = 8'h20;
  // Special function codes
  localparam logic [15:0] CODE_FORCE_ON = 16'h0196;
  localparam logic [15:0] CODE_FORCE_OFF = 16'h0190;
  // Reset values and jog speed limit
  localparam logic [15:0] JOG_SPEED_RST = 16'h0014;
  localparam logic [15:0] JOG_SPEED_MAX = 16'h1388;
  localparam logic [23:0] OUTCFG_RST = 24'h543210;
  localparam logic [3:0] MENU_RST = 4'h0;
  // Menu entries
  localparam logic [3:0] MENU_FAULT_LAST = 4'h4;
  localparam logic [3:0] MENU_JOG = 4'h5;
  localparam logic [3:0] MENU_FORCED = 4'h6;
  localparam logic [3:0] MENU_INPUTS = 4'h7;
  localparam logic [3:0] MENU_OUTPUTS = 4'h9;
  // Sizes
  localparam int FAULT_DEPTH = 5;
  localparam int NUM_DI = 9;
  localparam int NUM_DO = 6;
  localparam int NUM_KEYS = 5;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHOW = 2'b01,
    ST_EDIT = 2'b10,
    ST_JOG = 2'b11
  } iofdj_state_t;
endpackage

// file: verilog/iofdj_sync.sv
`timescale 1ns/1ps
`default_nettype none
module iofdj_sync #(
  parameter int W = 15
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] rise
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // Two-stage synchroniser, third stage only for edges
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign q = s2_reg;
  assign rise = s2_reg & ~s3_reg;
endmodule
`default_nettype wire

// file: verilog/iofdj_top.sv
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module iofdj_top #(
  parameter int NDI = iofdj_pkg::NUM_DI,
  parameter int NDO = iofdj_pkg::NUM_DO
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic key_set,
  input wire logic key_mode,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic key_shift,
  input wire logic drive_enable,
  input wire logic [NDI-1:0] discrete_input_line,
  input wire logic [7:0] func_status,
  input wire logic fault_event,
  input wire logic [15:0] fault_code,
  output logic [NDO-1:0] discrete_output_line,
  output logic jog_ccw,
  output logic jog_cw,
  output logic [15:0] speed_cmd,
  output logic [19:0] disp_value,
  output logic [4:0] disp_blank,
  output logic [4:0] disp_blink,
  output logic disp_jog
);
  localparam int SW = iofdj_pkg::NUM_KEYS + 1 + NDI;

  logic [SW-1:0] sync_q;
  logic [SW-1:0] sync_rise;
  logic set_rise, mode_rise, up_rise, down_rise, shift_rise;
  logic up_lvl, down_lvl, drv_en;
  logic [NDI-1:0] din_s;

  iofdj_sync #(.W(SW)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({key_set, key_mode, key_up, key_down, key_shift, drive_enable, discrete_input_line}),
    .q(sync_q),
    .rise(sync_rise)
  );

  assign {set_rise, mode_rise, up_rise, down_rise, shift_rise} = sync_rise[SW-1 -: 5];
  assign up_lvl = sync_q[SW-3];
  assign down_lvl = sync_q[SW-4];
  assign drv_en = sync_q[NDI];
  assign din_s = sync_q[NDI-1:0];

  // Register state
  logic [3:0] menu_reg, menu_next;
  logic force_en_reg, force_en_next;
  logic [15:0] forced_reg, forced_next;
  logic [23:0] outcfg_reg, outcfg_next;
  logic [15:0] jog_speed_reg, jog_speed_next;
  logic [1:0] cursor_reg, cursor_next;
  iofdj_pkg::iofdj_state_t state_reg, state_next;
  logic [15:0] hist_reg [iofdj_pkg::FAULT_DEPTH];
  logic [15:0] hist_next [iofdj_pkg::FAULT_DEPTH];
  logic [31:0] prdata_next;
  logic pready_next, pslverr_next, wr_fire, rd_phase;
  logic [15:0] step;
  logic [15:0] hist_sel;

  assign wr_fire = psel & penable & pready & pwrite;
  assign rd_phase = psel & penable & ~pready;
  assign hist_sel = (menu_reg <= iofdj_pkg::MENU_FAULT_LAST) ? hist_reg[menu_reg[2:0]] : 16'h0000;

  // Fault history shift log, newest in entry 0
  genvar gi;
  generate
    for (gi = 0; gi < iofdj_pkg::FAULT_DEPTH; gi++) begin : g_hist
      always_comb begin
        hist_next[gi] = hist_reg[gi];
        if (fault_event) hist_next[gi] = (gi == 0) ? fault_code : hist_reg[(gi == 0) ? 0 : gi - 1];
      end
      always_ff @(posedge clk) begin
        if (rst) begin
          hist_reg[gi] <= 16'h0000;
        end else begin
          hist_reg[gi] <= hist_next[gi];
        end
      end
    end
  endgenerate

  // Normal output mapping
  logic [NDO-1:0] normal_do;
  generate
    for (gi = 0; gi < NDO; gi++) begin : g_do
      assign normal_do[gi] = func_status[outcfg_reg[4*gi +: 3]] ^ outcfg_reg[4*gi+3];
    end
  endgenerate

  // APB slave
  always_comb begin
    pready_next = psel & penable & ~pready;
    pslverr_next = 1'b0;
    prdata_next = 32'h0000_0000;
    if (rd_phase) begin
      if (paddr == iofdj_pkg::OFF_MENU) begin
        prdata_next = {28'h0000000, menu_reg};
      end else if (paddr == iofdj_pkg::OFF_SPECIAL) begin
        prdata_next = {31'h0, force_en_reg};
      end else if (paddr == iofdj_pkg::OFF_FORCED) begin
        prdata_next = {16'h0000, forced_reg};
      end else if (paddr == iofdj_pkg::OFF_OUTCFG) begin
        prdata_next = {8'h00, outcfg_reg};
      end else if (paddr == iofdj_pkg::OFF_JOGSPD) begin
        prdata_next = {16'h0000, jog_speed_reg};
      end else if (paddr == iofdj_pkg::OFF_STATUS) begin
        prdata_next = {4'h0, drv_en, state_reg, force_en_reg, 2'h0, discrete_output_line,
                       7'h00, din_s};
      end else if (paddr == iofdj_pkg::OFF_DISPLAY) begin
        prdata_next = {disp_jog, 11'h000, disp_value};
      end else if (paddr >= iofdj_pkg::OFF_FAULT0 &&
                   paddr < iofdj_pkg::OFF_FAULT0 + 8'h14 && paddr[1:0] == 2'b00) begin
        prdata_next = {16'h0000, hist_reg[3'(paddr[4:2])]};
      end else begin
        pslverr_next = 1'b1;
      end
    end
    if (psel & penable & ~pready & pwrite) begin
      if (!(paddr inside {iofdj_pkg::OFF_MENU, iofdj_pkg::OFF_SPECIAL, iofdj_pkg::OFF_FORCED,
            iofdj_pkg::OFF_OUTCFG, iofdj_pkg::OFF_JOGSPD})) begin
        pslverr_next = 1'b1;
      end
    end
  end

  // Cursor step size
  always_comb begin
    case (cursor_reg)
      2'h0: step = 16'h0001;
      2'h1: step = 16'h000A;
      2'h2: step = 16'h0064;
      default: step = 16'h03E8;
    endcase
  end

  // Control next state
  always_comb begin
    menu_next = menu_reg;
    force_en_next = force_en_reg;
    forced_next = forced_reg;
    outcfg_next = outcfg_reg;
    jog_speed_next = jog_speed_reg;
    cursor_next = cursor_reg;
    state_next = state_reg;
    if (wr_fire) begin
      if (paddr == iofdj_pkg::OFF_MENU) begin
        menu_next = pwdata[3:0];
      end else if (paddr == iofdj_pkg::OFF_SPECIAL) begin
        if (pwdata[15:0] == iofdj_pkg::CODE_FORCE_ON) begin
          force_en_next = 1'b1;
        end else if (pwdata[15:0] == iofdj_pkg::CODE_FORCE_OFF) begin
          force_en_next = 1'b0;
        end
      end else if (paddr == iofdj_pkg::OFF_FORCED) begin
        forced_next = pwdata[15:0];
      end else if (paddr == iofdj_pkg::OFF_OUTCFG) begin
        outcfg_next = pwdata[23:0];
      end else if (paddr == iofdj_pkg::OFF_JOGSPD) begin
        jog_speed_next = (pwdata[15:0] > iofdj_pkg::JOG_SPEED_MAX) ?
                         iofdj_pkg::JOG_SPEED_MAX : pwdata[15:0];
      end
    end
    case (state_reg)
      iofdj_pkg::ST_IDLE: begin
        if (set_rise) begin
          state_next = (menu_reg == iofdj_pkg::MENU_JOG) ? iofdj_pkg::ST_EDIT :
                       iofdj_pkg::ST_SHOW;
          cursor_next = 2'h0;
        end
      end
      iofdj_pkg::ST_SHOW: begin
        if (mode_rise) begin
          state_next = iofdj_pkg::ST_IDLE;
        end
      end
      iofdj_pkg::ST_EDIT: begin
        if (set_rise) begin
          state_next = iofdj_pkg::ST_JOG;
        end else if (mode_rise) begin
          state_next = iofdj_pkg::ST_IDLE;
        end else if (shift_rise) begin
          cursor_next = cursor_reg + 2'h1;
        end else if (up_rise) begin
          jog_speed_next = (jog_speed_reg > iofdj_pkg::JOG_SPEED_MAX - step) ?
                           iofdj_pkg::JOG_SPEED_MAX : jog_speed_reg + step;
        end else if (down_rise) begin
          jog_speed_next = (jog_speed_reg < step) ? 16'h0000 : jog_speed_reg - step;
        end
      end
      default: begin
        if (mode_rise) begin
          state_next = iofdj_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // Output next values
  logic [NDO-1:0] do_next;
  logic ccw_next, cw_next;
  logic [15:0] speed_next;
  logic [19:0] dval_next;
  logic [4:0] blank_next, blink_next;
  logic hex_view;
  always_comb begin
    do_next = (force_en_reg & ~drv_en) ? forced_reg[NDO-1:0] : normal_do;
    ccw_next = (state_reg == iofdj_pkg::ST_JOG) & drv_en & up_lvl;
    cw_next = (state_reg == iofdj_pkg::ST_JOG) & drv_en & down_lvl & ~up_lvl;
    speed_next = (ccw_next | cw_next) ? jog_speed_reg : 16'h0000;
    hex_view = 1'b0;
    dval_next = {16'h0000, menu_reg};
    if (state_reg == iofdj_pkg::ST_EDIT || state_reg == iofdj_pkg::ST_JOG) begin
      dval_next = {4'h0, jog_speed_reg};
    end else if (state_reg == iofdj_pkg::ST_SHOW) begin
      hex_view = 1'b1;
      if (menu_reg <= iofdj_pkg::MENU_FAULT_LAST) begin
        dval_next = {4'h0, hist_sel};
      end else if (menu_reg == iofdj_pkg::MENU_FORCED) begin
        dval_next = {4'h0, forced_reg};
      end else if (menu_reg == iofdj_pkg::MENU_INPUTS) begin
        dval_next = {{(20-NDI){1'b0}}, din_s};
      end else if (menu_reg == iofdj_pkg::MENU_OUTPUTS) begin
        dval_next = {{(20-NDO){1'b0}}, discrete_output_line};
      end
    end
    blank_next = {hex_view & (dval_next[19:16] == 4'h0), 4'h0};
    blink_next = (state_next == iofdj_pkg::ST_EDIT) ? 5'(5'h01 << cursor_next) : 5'h00;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      menu_reg <= iofdj_pkg::MENU_RST;
      force_en_reg <= 1'b0;
      forced_reg <= 16'h0000;
      outcfg_reg <= iofdj_pkg::OUTCFG_RST;
      jog_speed_reg <= iofdj_pkg::JOG_SPEED_RST;
      cursor_reg <= 2'h0;
      state_reg <= iofdj_pkg::ST_IDLE;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      discrete_output_line <= '0;
      jog_ccw <= 1'b0;
      jog_cw <= 1'b0;
      speed_cmd <= 16'h0000;
      disp_value <= 20'h00000;
      disp_blank <= 5'h00;
      disp_blink <= 5'h00;
      disp_jog <= 1'b0;
    end else begin
      menu_reg <= menu_next;
      force_en_reg <= force_en_next;
      forced_reg <= forced_next;
      outcfg_reg <= outcfg_next;
      jog_speed_reg <= jog_speed_next;
      cursor_reg <= cursor_next;
      state_reg <= state_next;
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
      discrete_output_line <= do_next;
      jog_ccw <= ccw_next;
      jog_cw <= cw_next;
      speed_cmd <= speed_next;
      disp_value <= dval_next;
      disp_blank <= blank_next;
      disp_blink <= blink_next;
      disp_jog <= (state_next == iofdj_pkg::ST_JOG);
    end
  end

  AST_FAULT_SHOW: assert property (@(posedge clk) disable iff (rst)
    (state_reg == iofdj_pkg::ST_SHOW && menu_reg <= iofdj_pkg::MENU_FAULT_LAST)
    |=> disp_value == {4'h0, $past(hist_sel)})
    else $error("Fault entry not shown");
  AST_JOG_DEFAULT: assert property (@(posedge clk) rst |=> jog_speed_reg == iofdj_pkg::JOG_SPEED_RST)
    else $error("Jog speed default wrong");
  AST_SHIFT_CURSOR: assert property (@(posedge clk) disable iff (rst)
    (state_reg == iofdj_pkg::ST_EDIT && !set_rise && !mode_rise && shift_rise) |=>
    cursor_reg == $past(cursor_reg) + 2'h1 && disp_blink == 5'(5'h01 << cursor_reg))
    else $error("Cursor did not move");
  AST_SET_JOG: assert property (@(posedge clk) disable iff (rst)
    (state_reg == iofdj_pkg::ST_EDIT && set_rise) |=> state_reg == iofdj_pkg::ST_JOG && disp_jog)
    else $error("Set did not enter jog");
  AST_JOG_HELD: assert property (@(posedge clk) disable iff (rst)
    (state_reg == iofdj_pkg::ST_JOG && drv_en && up_lvl) |=> jog_ccw && !jog_cw &&
    speed_cmd == $past(jog_speed_reg))
    else $error("Jog CCW missing");
  AST_JOG_RELEASE: assert property (@(posedge clk) disable iff (rst)
    (!up_lvl && !down_lvl) |=> !jog_ccw && !jog_cw && speed_cmd == 16'h0000)
    else $error("Jog ran without key");
  AST_MODE_EXIT: assert property (@(posedge clk) disable iff (rst)
    (state_reg == iofdj_pkg::ST_JOG && mode_rise) |=> state_reg == iofdj_pkg::ST_IDLE ##1 !disp_jog)
    else $error("Mode did not leave jog");
  AST_JOG_NEEDS_ENABLE: assert property (@(posedge clk) disable iff (rst)
    !drv_en |=> !jog_ccw && !jog_cw)
    else $error("Jog while drive disabled");
  AST_FORCE_APPLY: assert property (@(posedge clk) disable iff (rst)
    (force_en_reg && !drv_en) |=> discrete_output_line == $past(forced_reg[NDO-1:0]))
    else $error("Forced bitmap not applied");
  AST_FORCE_CODES: assert property (@(posedge clk) disable iff (rst)
    (wr_fire && paddr == iofdj_pkg::OFF_SPECIAL && pwdata[15:0] == iofdj_pkg::CODE_FORCE_OFF)
    |=> !force_en_reg ##1 (drv_en || discrete_output_line == $past(normal_do)))
    else $error("Code 400 did not restore");
  AST_NORMAL_ENABLED: assert property (@(posedge clk) disable iff (rst)
    drv_en |=> discrete_output_line == $past(normal_do))
    else $error("Forcing while drive enabled");
endmodule
`default_nettype wire

// file: bench/iofdj_kpad.sv
`timescale 1ns/1ps
`default_nettype none
module iofdj_kpad (
  input wire logic clk,
  output logic [4:0] keys,
  output logic drive_enable,
  output logic [8:0] discrete_input_line
);
  // Keys {shift,down,up,mode,set}, all released at start
  initial begin
    keys = 5'h00;
    drive_enable = 1'b0;
    discrete_input_line = 9'h000;
  end
  task automatic set_keys(input logic [4:0] k);
    @(posedge clk);
    keys <= k;
  endtask
  task automatic set_en(input logic en);
    @(posedge clk);
    drive_enable <= en;
  endtask
  task automatic set_di(input logic [8:0] d);
    @(posedge clk);
    discrete_input_line <= d;
  endtask
endmodule
`default_nettype wire

// file: bench/io_force_diag_jog_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module io_force_diag_jog_bench;
  logic clk;
  logic rst;
  logic psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready, pslverr;
  wire logic [4:0] keys;
  wire logic den;
  wire logic [8:0] di;
  logic [7:0] fstat;
  logic fev;
  logic [15:0] fcode;
  logic [5:0] dout;
  logic ccw, cw, djog;
  logic [15:0] spd;
  logic [19:0] dval;
  logic [4:0] dblank, dblink;
  int miscompares = 0;
  int total_checks = 0;
  logic [31:0] r;
  logic e;

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  iofdj_kpad u_kp (.clk(clk), .keys(keys), .drive_enable(den), .discrete_input_line(di));

  iofdj_top u_dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_set(keys[0]), .key_mode(keys[1]), .key_up(keys[2]), .key_down(keys[3]),
    .key_shift(keys[4]), .drive_enable(den), .discrete_input_line(di),
    .func_status(fstat), .fault_event(fev), .fault_code(fcode),
    .discrete_output_line(dout), .jog_ccw(ccw), .jog_cw(cw), .speed_cmd(spd),
    .disp_value(dval), .disp_blank(dblank), .disp_blink(dblink), .disp_jog(djog)
  );

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // APB transfer, held until pready is seen at an edge or 50 edges pass
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h00000000);
    `CHK(r, x)
  endtask

  task automatic fault(input logic [15:0] c);
    @(posedge clk);
    fev <= 1'b1;
    fcode <= c;
    @(posedge clk);
    fev <= 1'b0;
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic press(input logic [4:0] k);
    u_kp.set_keys(k);
    waitc(8);
    u_kp.set_keys(5'h00);
    waitc(8);
  endtask

  initial begin
    waitc(20000);
    miscompares++;
    give_verdict;
  end

  initial begin
    rst <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h00000000;
    fstat <= 8'h00;
    fev <= 1'b0;
    fcode <= 16'h0000;
    waitc(3);
    rst <= 1'b0;
    rchk(iofdj_pkg::OFF_JOGSPD, 32'h00000014);
    rchk(iofdj_pkg::OFF_SPECIAL, 32'h00000000);
    rchk(iofdj_pkg::OFF_FORCED, 32'h00000000);
    rchk(iofdj_pkg::OFF_OUTCFG, 32'h00543210);
    rchk(8'h1C, 32'h00000000);
    `CHK(e, 1'b1)
    $display("test reset_values done");

    apb(1'b1, iofdj_pkg::OFF_MENU, 32'h00000005);
    press(5'h01);
    `CHK(dval, 20'h00014)
    `CHK(dblink, 5'h01)
    press(5'h04);
    `CHK(dval, 20'h00015)
    press(5'h10);
    `CHK(dblink, 5'h02)
    press(5'h04);
    `CHK(dval, 20'h0001F)
    press(5'h01);
    `CHK(djog, 1'b1)
    rchk(iofdj_pkg::OFF_JOGSPD, 32'h0000001F);
    rchk(iofdj_pkg::OFF_DISPLAY, 32'h8000001F);
    u_kp.set_keys(5'h04);
    waitc(8);
    `CHK(ccw, 1'b0)
    `CHK(spd, 16'h0000)
    u_kp.set_keys(5'h00);
    u_kp.set_en(1'b1);
    waitc(8);
    u_kp.set_keys(5'h04);
    waitc(8);
    `CHK(ccw, 1'b1)
    `CHK(cw, 1'b0)
    `CHK(spd, 16'h001F)
    u_kp.set_keys(5'h00);
    waitc(8);
    `CHK(ccw, 1'b0)
    `CHK(spd, 16'h0000)
    u_kp.set_keys(5'h08);
    waitc(8);
    `CHK(cw, 1'b1)
    u_kp.set_keys(5'h00);
    waitc(8);
    `CHK(cw, 1'b0)
    press(5'h02);
    `CHK(djog, 1'b0)
    press(5'h01);
    `CHK(dval, 20'h0001F)
    press(5'h01);
    press(5'h02);
    u_kp.set_en(1'b0);
    $display("test jog done");

    fault(16'hABCD);
    rchk(iofdj_pkg::OFF_FAULT0, 32'h0000ABCD);
    fault(16'h1234);
    rchk(iofdj_pkg::OFF_FAULT0, 32'h00001234);
    rchk(iofdj_pkg::OFF_FAULT0 + 8'h04, 32'h0000ABCD);
    apb(1'b1, iofdj_pkg::OFF_MENU, 32'h00000001);
    press(5'h01);
    `CHK(dval, 20'h0ABCD)
    `CHK(dblank[4], 1'b1)
    press(5'h02);
    u_kp.set_di(9'h1E1);
    apb(1'b1, iofdj_pkg::OFF_MENU, 32'h00000007);
    press(5'h01);
    `CHK(dval, 20'h001E1)
    press(5'h02);
    rchk(iofdj_pkg::OFF_STATUS, 32'h000001E1);
    `CHK(r[8:0], 9'h1E1)
    $display("test views done");

    fstat <= 8'h2D;
    apb(1'b1, iofdj_pkg::OFF_SPECIAL, 32'h00000196);
    apb(1'b1, iofdj_pkg::OFF_FORCED, 32'h00000007);
    waitc(4);
    `CHK(dout, 6'h07)
    apb(1'b1, iofdj_pkg::OFF_FORCED, 32'h00000002);
    waitc(4);
    `CHK(dout, 6'h02)
    apb(1'b0, iofdj_pkg::OFF_STATUS, 32'h00000000);
    `CHK(r[21:16], 6'h02)
    `CHK(r[24], 1'b1)
    apb(1'b1, iofdj_pkg::OFF_MENU, 32'h00000006);
    press(5'h01);
    `CHK(dval, 20'h00002)
    `CHK(dblank[4], 1'b1)
    press(5'h02);
    apb(1'b1, iofdj_pkg::OFF_MENU, 32'h00000009);
    press(5'h01);
    `CHK(dval, 20'h00002)
    press(5'h02);
    u_kp.set_en(1'b1);
    waitc(8);
    `CHK(dout, 6'h2D)
    apb(1'b1, iofdj_pkg::OFF_OUTCFG, 32'h00543218);
    waitc(4);
    `CHK(dout, 6'h2C)
    u_kp.set_en(1'b0);
    waitc(8);
    `CHK(dout, 6'h02)
    apb(1'b1, iofdj_pkg::OFF_SPECIAL, 32'h00000190);
    waitc(4);
    `CHK(dout, 6'h2C)
    apb(1'b1, iofdj_pkg::OFF_SPECIAL, 32'h00000196);
    rst <= 1'b1;
    waitc(3);
    rst <= 1'b0;
    rchk(iofdj_pkg::OFF_SPECIAL, 32'h00000000);
    rchk(iofdj_pkg::OFF_FORCED, 32'h00000000);
    waitc(4);
    `CHK(dout, 6'h2D)
    $display("test forced done");
    give_verdict;
  end
endmodule
`default_nettype wire
